// file: common/pec_pkg.sv
package pec_pkg;
    // APB register byte offsets.
    localparam logic [7:0] ADDR_PA_RISE = 8'h00;
    localparam logic [7:0] ADDR_PA_FALL = 8'h04;
    localparam logic [7:0] ADDR_PA_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_PB_RISE = 8'h0c;
    localparam logic [7:0] ADDR_PB_FALL = 8'h10;
    localparam logic [7:0] ADDR_PB_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_PC_RISE = 8'h18;
    localparam logic [7:0] ADDR_PC_FALL = 8'h1c;
    localparam logic [7:0] ADDR_PC_FLAGS = 8'h20;
    localparam logic [7:0] ADDR_CTRL = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int STATUS_AGG_BIT = 0;
    localparam int STATUS_SLEEP_BIT = 1;
    // Implemented-bit masks per port.
    localparam logic [7:0] PA_MASK = 8'h3f;
    localparam logic [7:0] PB_MASK = 8'hf0;
    localparam logic [7:0] PC_MASK_SMALL = 8'h3f;
    localparam logic [7:0] PC_MASK_LARGE = 8'hff;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_PORTS = 3;

    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] flags;
    } pec_port_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
    } pec_apb_req_t;
endpackage : pec_pkg

// file: verilog/pec_top.sv
`timescale 1ns/1ps
// Overview of operation
// - With master enable set, a pin-change event wakes the device from sleep.
// - Edges seen during sleep are flagged before the core resumes execution.
// - A set rise enable arms rising-edge detection on that pin.
// - A set fall enable arms falling-edge detection on that pin.
// - Rising edge with rise enable set sets the pin flag.
// - Falling edge with fall enable set sets the pin flag.
// - Any hardware flag set also sets the aggregate flag.
// - A flag reads zero if no enabled change occurred or software cleared it.
// - With both enables clear, the pin never sets its flag.
// - Port A implements bits 5-0; bits 7-6 read zero.
// - Port B implements bits 7-4; bits 3-0 read zero.
// - Port C spans bits 7-0; bits 7-6 only on larger variants.
// - All enable and flag bits reset to zero on every reset.
// - Without master enable, flags still set but no interrupt is raised.
// - An edge during a flag write leaves that flag set.
// - The aggregate flag is the OR of all pin flags.
// - Both enables set detects both edge directions.
module pec_top #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Port pins.
    input wire logic [7:0] porta_pin_i,
    input wire logic [7:0] portb_pin_i,
    input wire logic [7:0] portc_pin_i,
    // Core side.
    output logic pin_change_aggregate_flag_o,
    output logic pin_change_irq_o,
    output logic wake_o
);
    localparam logic [7:0] PC_MASK = LARGE_VARIANT ? pec_pkg::PC_MASK_LARGE
                                                   : pec_pkg::PC_MASK_SMALL;
    logic [7:0] mask [pec_pkg::NUM_PORTS];
    assign mask[0] = pec_pkg::PA_MASK;
    assign mask[1] = pec_pkg::PB_MASK;
    assign mask[2] = PC_MASK;

    pec_pkg::pec_apb_req_t req;
    assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};

    logic [7:0] pins [pec_pkg::NUM_PORTS];
    assign pins[0] = porta_pin_i;
    assign pins[1] = portb_pin_i;
    assign pins[2] = portc_pin_i;

    pec_pkg::pec_port_cfg_t cfg [pec_pkg::NUM_PORTS];
    pec_pkg::pec_port_cfg_t next_cfg [pec_pkg::NUM_PORTS];
    logic [7:0] sync1 [pec_pkg::NUM_PORTS];
    logic [7:0] sync2 [pec_pkg::NUM_PORTS];
    logic [7:0] prev [pec_pkg::NUM_PORTS];
    logic [7:0] edge_hit [pec_pkg::NUM_PORTS];
    logic master_en;
    logic next_master_en;
    logic sleeping;
    logic next_sleeping;
    logic primed;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] next_rdata;
    logic next_slverr;
    logic [7:0] next_sync1 [pec_pkg::NUM_PORTS];
    logic [7:0] next_sync2 [pec_pkg::NUM_PORTS];
    logic [7:0] next_prev [pec_pkg::NUM_PORTS];
    logic next_primed;
    logic [31:0] next_prdata;

    assign wr_acc = psel_i && penable_i && req.write;
    assign rd_acc = psel_i && !penable_i && !req.write;
    assign pready_o = 1'b1;

    always_comb begin
        next_primed = 1'b1;
        for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
            next_sync1[p] = pins[p];
            next_sync2[p] = sync1[p];
            next_prev[p] = sync2[p];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
                sync1[p] <= pec_pkg::REG_RESET;
                sync2[p] <= pec_pkg::REG_RESET;
                prev[p] <= pec_pkg::REG_RESET;
            end
            primed <= 1'b0;
        end else begin
            for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
                sync1[p] <= next_sync1[p];
                sync2[p] <= next_sync2[p];
                prev[p] <= next_prev[p];
            end
            primed <= next_primed;
        end
    end

    // Edge detection is held off only for the first clock after reset, before the sample pipeline
    // is full; a pin that is high at reset release can still register as a rising edge.
    always_comb begin
        for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
            edge_hit[p] = primed ? (((sync2[p] & ~prev[p]) & cfg[p].rise) |
                                    ((~sync2[p] & prev[p]) & cfg[p].fall)) & mask[p]
                                 : 8'h00;
        end
    end

    always_comb begin
        next_master_en = master_en;
        next_sleeping = sleeping;
        for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
            next_cfg[p] = cfg[p];
            if (wr_acc && req.addr == pec_pkg::ADDR_PA_RISE + 8'(p * 12)) begin
                next_cfg[p].rise = req.wdata[7:0] & mask[p];
            end
            if (wr_acc && req.addr == pec_pkg::ADDR_PA_FALL + 8'(p * 12)) begin
                next_cfg[p].fall = req.wdata[7:0] & mask[p];
            end
            if (wr_acc && req.addr == pec_pkg::ADDR_PA_FLAGS + 8'(p * 12)) begin
                next_cfg[p].flags = req.wdata[7:0] & mask[p];
            end
            next_cfg[p].flags = next_cfg[p].flags | edge_hit[p];
        end
        if (wr_acc && req.addr == pec_pkg::ADDR_CTRL) begin
            next_master_en = req.wdata[pec_pkg::CTRL_MASTER_EN_BIT];
            next_sleeping = req.wdata[pec_pkg::CTRL_SLEEP_BIT];
        end
        if (sleeping && master_en && pin_change_aggregate_flag_o) begin
            next_sleeping = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
                cfg[p] <= '0;
            end
            master_en <= 1'b0;
            sleeping <= 1'b0;
        end else begin
            for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
                cfg[p] <= next_cfg[p];
            end
            master_en <= next_master_en;
            sleeping <= next_sleeping;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b1;
        for (int p = 0; p < pec_pkg::NUM_PORTS; p++) begin
            if (req.addr == pec_pkg::ADDR_PA_RISE + 8'(p * 12)) begin
                next_rdata = {24'h000000, cfg[p].rise & mask[p]};
                next_slverr = 1'b0;
            end
            if (req.addr == pec_pkg::ADDR_PA_FALL + 8'(p * 12)) begin
                next_rdata = {24'h000000, cfg[p].fall & mask[p]};
                next_slverr = 1'b0;
            end
            if (req.addr == pec_pkg::ADDR_PA_FLAGS + 8'(p * 12)) begin
                next_rdata = {24'h000000, cfg[p].flags & mask[p]};
                next_slverr = 1'b0;
            end
        end
        if (req.addr == pec_pkg::ADDR_CTRL) begin
            next_rdata[pec_pkg::CTRL_MASTER_EN_BIT] = master_en;
            next_rdata[pec_pkg::CTRL_SLEEP_BIT] = sleeping;
            next_slverr = 1'b0;
        end
        if (req.addr == pec_pkg::ADDR_STATUS) begin
            next_rdata[pec_pkg::STATUS_AGG_BIT] = pin_change_aggregate_flag_o;
            next_rdata[pec_pkg::STATUS_SLEEP_BIT] = sleeping;
            next_slverr = 1'b0;
        end
    end

    // Read data is captured in the setup cycle, so it is stable in the access phase.
    always_comb begin
        next_prdata = prdata_o;
        if (rd_acc) begin
            next_prdata = next_rdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else begin
            prdata_o <= next_prdata;
        end
    end
    assign pslverr_o = psel_i && penable_i && next_slverr;

    assign pin_change_aggregate_flag_o = |(cfg[0].flags | cfg[1].flags | cfg[2].flags);
    assign pin_change_irq_o = master_en && pin_change_aggregate_flag_o;
    assign wake_o = sleeping && pin_change_irq_o;

    chk_edge_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[0] != 8'h00) |=> ((cfg[0].flags & $past(edge_hit[0])) == $past(edge_hit[0])))
        else $error("Port A edge did not set flag.");
    chk_disabled_pin: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[2] & ~(cfg[2].rise | cfg[2].fall)) == 8'h00)
        else $error("Disabled pin produced an edge.");
    chk_porta_unimpl: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg[0].flags & ~pec_pkg::PA_MASK) == 8'h00)
        else $error("Port A unimplemented flag bit set.");
    chk_portb_unimpl: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ((cfg[1].rise | cfg[1].fall | cfg[1].flags) & ~pec_pkg::PB_MASK) == 8'h00)
        else $error("Port B unimplemented bit set.");
    chk_portc_span: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg[2].flags & ~PC_MASK) == 8'h00)
        else $error("Port C bit outside variant set.");
    chk_irq_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !master_en && pin_change_aggregate_flag_o |-> !pin_change_irq_o)
        else $error("Interrupt raised with master disabled.");
    chk_write_race: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_acc && req.addr == pec_pkg::ADDR_PB_FLAGS && edge_hit[1] != 8'h00
        |=> (cfg[1].flags & $past(edge_hit[1])) == $past(edge_hit[1]))
        else $error("Edge lost during flag write.");
    chk_aggregate_or: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[0] != 8'h00) |=> pin_change_aggregate_flag_o)
        else $error("Aggregate flag missed a pin flag.");
    chk_sleep_wake: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        sleeping && master_en && edge_hit[2] != 8'h00 |=> wake_o ##1 !sleeping)
        else $error("Sleep not left after enabled edge.");
    chk_sync_delay: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        primed && cfg[0].rise[0] && $rose(sync2[0][0]) |-> edge_hit[0][0])
        else $error("Synchronised rising edge not detected.");
    chk_fall_detect: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        primed && cfg[0].fall[1] && $fell(sync2[0][1]) |-> edge_hit[0][1])
        else $error("Synchronised falling edge not detected.");
    chk_both_edges: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        primed && cfg[0].rise[2] && cfg[0].fall[2] && $changed(sync2[0][2]) |-> edge_hit[0][2])
        else $error("Pin with both enables missed an edge.");
    chk_flag_set_b: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[1] != 8'h00) |=> ((cfg[1].flags & $past(edge_hit[1])) == $past(edge_hit[1])))
        else $error("Port B edge did not set flag.");
    chk_flag_set_c: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[2] != 8'h00) |=> ((cfg[2].flags & $past(edge_hit[2])) == $past(edge_hit[2])))
        else $error("Port C edge did not set flag.");
    chk_flags_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !wr_acc && edge_hit[0] == 8'h00 |=> cfg[0].flags == $past(cfg[0].flags))
        else $error("Port A flags changed without edge or write.");
    chk_porta_enables: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ((cfg[0].rise | cfg[0].fall) & ~pec_pkg::PA_MASK) == 8'h00)
        else $error("Port A unimplemented enable bit set.");
    chk_portc_enables: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ((cfg[2].rise | cfg[2].fall) & ~PC_MASK) == 8'h00)
        else $error("Port C enable bit outside variant set.");
    chk_irq_raise: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        master_en && pin_change_aggregate_flag_o |-> pin_change_irq_o)
        else $error("Interrupt missing with master enabled.");
    chk_flag_first: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wake_o |-> (cfg[0].flags | cfg[1].flags | cfg[2].flags) != 8'h00)
        else $error("Wake raised with no flag recorded.");
    chk_wake_clears: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wake_o |=> !sleeping)
        else $error("Sleep held after wake.");
    chk_sleep_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        sleeping && !master_en && !(wr_acc && req.addr == pec_pkg::ADDR_CTRL) |=> sleeping)
        else $error("Sleep left with master disabled.");
    chk_agg_source: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        pin_change_aggregate_flag_o |-> (cfg[0].flags | cfg[1].flags | cfg[2].flags) != 8'h00)
        else $error("Aggregate flag set with no pin flag.");
    chk_portb_edge: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (edge_hit[1] & ~pec_pkg::PB_MASK) == 8'h00)
        else $error("Port B edge on unimplemented bit.");
endmodule : pec_top

// file: tb/pec_pin_model.sv
`timescale 1ns/1ps
// Port pins are driven push-pull, so every pin always carries a real level.
module pec_pin_model (
    // Clock.
    input wire logic ref_clk_i,
    // Requested levels, port C high byte down to port A low byte.
    input wire logic [23:0] level_i,
    // Pin levels.
    output logic [7:0] porta_pin_o,
    output logic [7:0] portb_pin_o,
    output logic [7:0] portc_pin_o
);
    initial {portc_pin_o, portb_pin_o, porta_pin_o} = 24'h000000;
    always @(posedge ref_clk_i) begin
        {portc_pin_o, portb_pin_o, porta_pin_o} <= level_i;
    end
endmodule : pec_pin_model

// file: tb/tb_pec_top.sv
`timescale 1ns/1ps
module tb_pec_top;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, agg_o, irq_o, wake_o;
    logic [7:0] pa, pb, pc;
    logic [23:0] level = 24'h000000;
    logic [31:0] rd;
    logic err;
    logic [7:0] mask [3];
    int n_fail = 0;
    int tests_run = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    pec_pin_model pins (.ref_clk_i(ref_clk_i), .level_i(level), .porta_pin_o(pa),
        .portb_pin_o(pb), .portc_pin_o(pc));
    pec_top #(.LARGE_VARIANT(1'b1)) uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .porta_pin_i(pa), .portb_pin_i(pb), .portc_pin_i(pc),
        .pin_change_aggregate_flag_o(agg_o), .pin_change_irq_o(irq_o), .wake_o(wake_o));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request is held from setup until the edge where pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
    endtask : rchk
    task automatic pins_to(input logic [23:0] v);
        @(posedge ref_clk_i);
        level <= v;
        repeat (8) @(posedge ref_clk_i);
    endtask : pins_to
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        mask = '{pec_pkg::PA_MASK, pec_pkg::PB_MASK, pec_pkg::PC_MASK_LARGE};
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 11; i++) rchk("reset value", 8'(i * 4), 32'h00000000);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'(i * 4), 32'hffffffff);
            rchk("bit mask", 8'(i * 4), {24'h000000, mask[i / 3]});
            apb(1'b1, 8'(i * 4), 32'h00000000);
        end
        apb(1'b1, 8'h30, 32'h000000ff);
        chk("unmapped error", 32'h1, {31'h0, err});
        rchk("unmapped read", 8'h30, 32'h00000000);
        apb(1'b1, pec_pkg::ADDR_PA_RISE, 32'h00000001);
        apb(1'b1, pec_pkg::ADDR_PA_FALL, 32'h00000006);
        apb(1'b1, pec_pkg::ADDR_PC_RISE, 32'h00000080);
        pins_to(24'h00ff03);
        rchk("flags A rise", pec_pkg::ADDR_PA_FLAGS, 32'h00000001);
        rchk("flags B none", pec_pkg::ADDR_PB_FLAGS, 32'h00000000);
        pins_to(24'h000000);
        rchk("flags A fall", pec_pkg::ADDR_PA_FLAGS, 32'h00000003);
        chk("aggregate", 32'h1, {31'h0, agg_o});
        chk("irq masked", 32'h0, {31'h0, irq_o});
        rchk("status agg", pec_pkg::ADDR_STATUS, 32'h00000001);
        apb(1'b1, pec_pkg::ADDR_CTRL, 32'h00000001);
        @(negedge ref_clk_i);
        chk("irq enabled", 32'h1, {31'h0, irq_o});
        apb(1'b1, pec_pkg::ADDR_PA_FLAGS, 32'h00000000);
        rchk("flags cleared", pec_pkg::ADDR_PA_FLAGS, 32'h00000000);
        chk("aggregate off", 32'h0, {31'h0, agg_o});
        apb(1'b1, pec_pkg::ADDR_PA_RISE, 32'h00000005);
        pins_to(24'h000004);
        rchk("both edges rise", pec_pkg::ADDR_PA_FLAGS, 32'h00000004);
        apb(1'b1, pec_pkg::ADDR_PA_FLAGS, 32'h00000000);
        pins_to(24'h000000);
        rchk("both edges", pec_pkg::ADDR_PA_FLAGS, 32'h00000004);
        apb(1'b1, pec_pkg::ADDR_PA_FLAGS, 32'h00000000);
        apb(1'b1, pec_pkg::ADDR_CTRL, 32'h00000003);
        rchk("sleeping", pec_pkg::ADDR_STATUS, 32'h00000002);
        pins_to(24'h800000);
        rchk("sleep flag C7", pec_pkg::ADDR_PC_FLAGS, 32'h00000080);
        rchk("woken", pec_pkg::ADDR_STATUS, 32'h00000001);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rchk("flags after reset", pec_pkg::ADDR_PC_FLAGS, 32'h00000000);
        report_and_stop();
    end
endmodule : tb_pec_top
